// ===== logic/ct_pkg.sv
// Shared constants and carriers for the dual counter/timer block.
// Assumes a single 10 MHz system clock and synchronous active-high reset.
package ct_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int          NUM_CH      = 2;
  localparam int          CNT_W       = 32;
  localparam int          HALF_W      = 16;
  localparam int          DUTY_W      = 7;
  localparam logic [31:0] DIV_MIN     = 32'h0000_0002;
  localparam logic [6:0]  DUTY_FULL   = 7'h64;
  localparam logic [31:0] CNT_RST     = 32'h0000_0000;
  localparam logic [31:0] ONE32       = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int TB_HZ  = 48_000_000;
  localparam int CLK_HZ = 10_000_000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    GATE_NONE = 3'b000,
    GATE_LOW  = 3'b001,
    GATE_HIGH = 3'b010,
    GATE_FALL = 3'b011,
    GATE_RISE = 3'b100
  } gate_e;

  typedef enum logic [0:0] {
    POL_HL = 1'b0,
    POL_LH = 1'b1
  } pol_e;

  typedef enum logic [0:0] {
    SRC_INT = 1'b0,
    SRC_EXT = 1'b1
  } src_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_RUN  = 2'b10
  } run_e;

  // ----------------------------------------------------------------
  // Per-channel configuration carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    src_e              src;
    gate_e             gate;
    pol_e              pol;
    logic [DUTY_W-1:0] duty;
    logic [CNT_W-1:0]  div;
  } ct_cfg_s;

endpackage

// ===== logic/ct_sync.sv
// Two-flop synchroniser with edge detection on the synchronised level.
// Assumes the input is asynchronous to clk.
module ct_sync
  import ct_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Flops follow the pin through reset, so a pin idling high
  // gives no false edge once reset lets go
  always_ff @(posedge clk) begin
    meta_r <= din;
    sync_r <= meta_r;
    last_r <= sync_r;
  end

  assign level = sync_r;
  assign rise  = sync_r & ~last_r & ~rst;
  assign fall  = ~sync_r & last_r & ~rst;

endmodule

// ===== logic/dual_ct.sv
// Two 32-bit counter/timer channels with clock select, gating, pulse out
// and a lower-word sample latch for the acquisition sampler.
// Assumes external clock and gate pins are asynchronous to clk.
//
// How it works
// - Two independent channels 0 and 1 each hold a 32-bit count, own clock and gate inputs and a pulse output.
// - A low-word sample returns bits 15:0 of the count and an optional high-word sample returns bits 31:16.
// - The low-word sample copies the full 32-bit count into a latch that the high-word sample reads.
// - Internal source advances from a 48 MHz time base and the divider sets the pulse output rate.
// - External source advances on rising edges of the channel clock input.
// - External source uses a divider from 2 to 4294967295, smaller values clamp to 2.
// - Gate none enables the channel two clocks after the start command is seen, passing through the arm state.
// - Low-level gate enables while the gate is low and disables while it is high.
// - High-level gate enables while the gate is high and disables while it is low.
// - Falling-edge gate enables the channel after a high-to-low gate transition.
// - Rising-edge gate enables the channel after a low-to-high gate transition.
// - High-to-low pulse type makes the low part of each period the active part.
// - Low-to-high pulse type makes the high part of each period the active part.
// - The active part lasts duty percent of the period, 50 giving equal halves.
module dual_ct
  import ct_pkg::*;
#(
  parameter int N_CH = NUM_CH
)(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire ct_cfg_s [N_CH-1:0]      cfg,
  input  wire logic [N_CH-1:0]         start,
  input  wire logic [N_CH-1:0]         stop,
  input  wire logic [N_CH-1:0]         ext_clk,
  input  wire logic [N_CH-1:0]         gate,
  input  wire logic [N_CH-1:0]         sample_lo,
  input  wire logic [N_CH-1:0]         sample_hi,
  output logic [N_CH-1:0]              pulse_out,
  output logic [N_CH-1:0]              running,
  output logic [N_CH-1:0][CNT_W-1:0]   count,
  output logic [N_CH-1:0][HALF_W-1:0]  sample_data,
  output logic [N_CH-1:0]              sample_valid
);

  // ----------------------------------------------------------------
  // Internal 48 MHz time base as fractional tick rate on 10 MHz clk
  // ----------------------------------------------------------------
  // Each clk cycle carries TB_HZ/CLK_HZ base ticks; the accumulator
  // spreads the remainder so the long-run rate is exact.
  localparam logic [31:0] TB_WHOLE = 32'(TB_HZ / CLK_HZ);
  localparam logic [31:0] TB_FRAC  = 32'(TB_HZ % CLK_HZ);
  localparam logic [31:0] TB_MOD   = 32'(CLK_HZ);

  logic [31:0] tb_acc_r;
  logic [31:0] tb_step;
  logic [31:0] tb_sum;

  always_comb begin
    tb_sum  = tb_acc_r + TB_FRAC;
    tb_step = TB_WHOLE;
    if (tb_sum >= TB_MOD) begin
      tb_step = TB_WHOLE + ONE32;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tb_acc_r <= CNT_RST;
    end else if (tb_sum >= TB_MOD) begin
      tb_acc_r <= tb_sum - TB_MOD;
    end else begin
      tb_acc_r <= tb_sum;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    logic        clk_rise;
    logic        gate_lvl, gate_rise, gate_fall;
    run_e        st_r;
    logic        enable;
    logic [31:0] div_eff;
    logic [31:0] step;
    logic [31:0] phase_r;
    logic [CNT_W:0] phase_sum;
    logic [31:0] act_len;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] latch_r;
    logic        active;
    logic        pulse_r;
    logic [HALF_W-1:0] sdata_r;
    logic        svalid_r;

    ct_sync u_clk_sync (
      .clk   (clk),
      .rst   (rst),
      .din   (ext_clk[i]),
      .level (),
      .rise  (clk_rise),
      .fall  ()
    );

    ct_sync u_gate_sync (
      .clk   (clk),
      .rst   (rst),
      .din   (gate[i]),
      .level (gate_lvl),
      .rise  (gate_rise),
      .fall  (gate_fall)
    );

    // Run state: software start arms, gate decides enable
    always_ff @(posedge clk) begin
      if (rst) begin
        st_r <= ST_IDLE;
      end else if (stop[i]) begin
        st_r <= ST_IDLE;
      end else begin
        case (st_r)
          ST_IDLE: begin
            if (start[i]) begin
              st_r <= ST_ARM;
            end
          end
          ST_ARM: begin
            case (cfg[i].gate)
              GATE_FALL: if (gate_fall) st_r <= ST_RUN;
              GATE_RISE: if (gate_rise) st_r <= ST_RUN;
              default:   st_r <= ST_RUN;
            endcase
          end
          ST_RUN:  st_r <= ST_RUN;
          default: st_r <= ST_IDLE;
        endcase
      end
    end

    always_comb begin
      case (cfg[i].gate)
        GATE_LOW:  enable = (st_r == ST_RUN) && !gate_lvl;
        GATE_HIGH: enable = (st_r == ST_RUN) && gate_lvl;
        default:   enable = (st_r == ST_RUN);
      endcase
    end

    // Divider, clamped to its legal floor
    assign div_eff = (cfg[i].div < DIV_MIN) ? DIV_MIN : cfg[i].div;

    // Ticks this cycle: 48 MHz base or one per external rising edge
    always_comb begin
      if (cfg[i].src == SRC_EXT) begin
        step = clk_rise ? ONE32 : CNT_RST;
      end else begin
        step = tb_step;
      end
    end

    // Spare bit: phase plus step may pass 2^32 near the top divider
    assign phase_sum = (CNT_W+1)'(phase_r) + (CNT_W+1)'(step);

    always_ff @(posedge clk) begin
      if (rst || !enable) begin
        phase_r <= CNT_RST;
      end else if (phase_sum >= (CNT_W+1)'(div_eff)) begin
        phase_r <= CNT_W'(phase_sum - (CNT_W+1)'(div_eff));
      end else begin
        phase_r <= phase_sum[CNT_W-1:0];
      end
    end

    // Count of base or external ticks while enabled
    always_ff @(posedge clk) begin
      if (rst || (st_r == ST_IDLE && start[i])) begin
        cnt_r <= CNT_RST;
      end else if (enable) begin
        cnt_r <= cnt_r + step;
      end
    end

    // Active length = div * duty / 100, in 64 bits to avoid overflow
    assign act_len = 32'((64'(div_eff) * 64'(cfg[i].duty)) / 64'(DUTY_FULL));
    assign active  = enable && (phase_r < act_len);

    always_ff @(posedge clk) begin
      if (rst) begin
        pulse_r <= 1'b0;
      end else if (cfg[i].pol == POL_LH) begin
        pulse_r <= active;
      end else begin
        pulse_r <= !active;
      end
    end

    // Sample path: low word latches the whole count
    always_ff @(posedge clk) begin
      if (rst) begin
        latch_r <= CNT_RST;
      end else if (sample_lo[i]) begin
        latch_r <= cnt_r;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        sdata_r  <= '0;
        svalid_r <= 1'b0;
      end else if (sample_lo[i]) begin
        sdata_r  <= cnt_r[HALF_W-1:0];
        svalid_r <= 1'b1;
      end else if (sample_hi[i]) begin
        sdata_r  <= latch_r[CNT_W-1:HALF_W];
        svalid_r <= 1'b1;
      end else begin
        svalid_r <= 1'b0;
      end
    end

    assign pulse_out[i]    = pulse_r;
    assign running[i]      = enable;
    assign count[i]        = cnt_r;
    assign sample_data[i]  = sdata_r;
    assign sample_valid[i] = svalid_r;
  end

endmodule

// ===== verif/dual_ct_properties.sv
// Concurrent checks on dual_ct: channel 1 for level gates and the run cover, channel 0 otherwise.
// Assumes a bind into every dual_ct instance.
module dual_ct_chk
  import ct_pkg::*;
#(
  parameter int N_CH = NUM_CH
)(
  input wire logic                         clk,
  input wire logic                         rst,
  input wire ct_cfg_s [N_CH-1:0]           cfg,
  input wire logic [N_CH-1:0]              start,
  input wire logic [N_CH-1:0]              stop,
  input wire logic [N_CH-1:0]              ext_clk,
  input wire logic [N_CH-1:0]              gate,
  input wire logic [N_CH-1:0]              sample_lo,
  input wire logic [N_CH-1:0]              sample_hi,
  input wire logic [N_CH-1:0]              pulse_out,
  input wire logic [N_CH-1:0]              running,
  input wire logic [N_CH-1:0][CNT_W-1:0]   count,
  input wire logic [N_CH-1:0][HALF_W-1:0]  sample_data,
  input wire logic [N_CH-1:0]              sample_valid
);
  logic [HALF_W-1:0] hi_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      hi_r <= 16'h0000;
    end else if (sample_lo[0]) begin
      hi_r <= count[0][31:16];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_sample_valid: assert property ((sample_lo[0] || sample_hi[0]) |=> sample_valid[0])
    else $error("sample valid missing");
  a_low_word: assert property (sample_lo[0] |=> sample_data[0] == $past(count[0][15:0]))
    else $error("low word wrong");
  a_high_latch: assert property (sample_hi[0] && !sample_lo[0] |=> sample_data[0] == $past(hi_r))
    else $error("high word not from latch");
  a_none_start: assert property (start[0] && !stop[0] && cfg[0].gate == GATE_NONE ##1 !stop[0]
    |=> running[0]) else $error("gate none not running");
  a_low_gate: assert property (cfg[1].gate == GATE_LOW && gate[1][*4] |-> !running[1])
    else $error("low gate runs while high");
  a_high_gate: assert property (cfg[1].gate == GATE_HIGH && !gate[1][*4] |-> !running[1])
    else $error("high gate runs while low");
  a_idle_level: assert property (!running[0][*2]
    |=> pulse_out[0] == ($past(cfg[0].pol) == POL_HL)) else $error("idle pulse level");
  a_ext_still: assert property ($stable(ext_clk[0])[*5] ##0 (!start[0] && cfg[0].src == SRC_EXT)
    |=> $stable(count[0])) else $error("count moved without edge");
  c_sample: cover property (sample_lo[0] ##[1:20] sample_hi[0]);
  c_run: cover property ($rose(running[1]));
  c_pulse: cover property ($rose(pulse_out[0]));
endmodule

bind dual_ct dual_ct_chk #(.N_CH(N_CH)) chk_i (.clk, .rst, .cfg, .start, .stop, .ext_clk,
  .gate, .sample_lo, .sample_hi, .pulse_out, .running, .count, .sample_data, .sample_valid);

// ===== verif/sig_src.sv
// External clock source for one counter channel.
// Assumes the bench raises en only for a burst of edges.
module sig_src #(
  parameter int HALF_NS = 500
)(
  input  wire logic en,
  output logic      sclk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial sclk = 1'b0;
  // Stands low between bursts
  always begin
    if (en) begin
      #(HALF_NS) sclk = en ? ~sclk : 1'b0;
    end else begin
      sclk = 1'b0;
      @(en);
    end
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for dual_ct: samples, gate types, pulse duty.
// Assumes sig_src drives the external clock pins.
module tb
  import ct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  ct_cfg_s [1:0]         cfg;
  logic [1:0]            start, stop, gate, sample_lo, sample_hi, src_en;
  logic [1:0]            ext_clk, pulse_out, running, sample_valid;
  logic [1:0][CNT_W-1:0] count;
  logic [1:0][15:0]      sample_data;
  logic [15:0]           exp_q[$];
  int                    mismatches = 0, n_compared = 0, cyc = 0, n, d, act, inact, c0;
  always #50 clk = ~clk;
  dual_ct dut (.clk, .rst, .cfg, .start, .stop, .ext_clk, .gate, .sample_lo, .sample_hi,
    .pulse_out, .running, .count, .sample_data, .sample_valid);
  sig_src src0 (.en(src_en[0]), .sclk(ext_clk[0]));
  sig_src src1 (.en(src_en[1]), .sclk(ext_clk[1]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(ref logic [1:0] s, input int ch);
    s[ch] = 1'b1;
    tick(1);
    s[ch] = 1'b0;
  endtask
  // Sample words against queued notes
  always @(negedge clk) begin
    if (sample_valid[0] === 1'b1) begin
      chk(sample_data[0], exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 10000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    cfg = '0;
    {start, stop, gate, sample_lo, sample_hi, src_en} = 12'h000;
    void'($urandom(56182));
    tick(10);
    rst = 1'b0;
    n = $urandom_range(40, 3);
    cfg[0] = '{SRC_EXT, GATE_NONE, POL_LH, 7'h32, 32'h0000_000a};
    pulse(start, 0);
    src_en[0] = 1'b1;
    #(n * 1000) src_en[0] = 1'b0;
    tick(6);
    exp_q.push_back(n[15:0]);
    pulse(sample_lo, 0);
    src_en[0] = 1'b1;
    #3000 src_en[0] = 1'b0;
    tick(6);
    exp_q.push_back(16'h0000);
    pulse(sample_hi, 0);
    tick(1);
    exp_q.push_back(16'(n + 3));
    pulse(sample_lo, 0);
    pulse(stop, 0);
    $display("test samples done");
    for (int g = 0; g < 5; g++) begin
      inact = (g == 1 || g == 3);
      cfg[1] = '{SRC_INT, gate_e'(g), POL_HL, 7'h32, 32'h0000_0010};
      gate[1] = inact[0];
      tick(4);
      pulse(start, 1);
      tick(6);
      chk(running[1], g == 0);
      gate[1] = !inact[0];
      tick(6);
      chk(running[1], 1'b1);
      gate[1] = inact[0];
      tick(6);
      chk(running[1], !(g == 1 || g == 2));
      pulse(stop, 1);
    end
    $display("test gates done");
    // Internal base: exactly 48 ticks per 10 clk cycles, whatever the phase
    cfg[1] = '{SRC_INT, GATE_NONE, POL_LH, 7'h32, 32'h0000_0030};
    tick(1);
    pulse(start, 1);
    tick(4);
    c0 = count[1];
    tick(50);
    chk(count[1] - c0, 32'(5 * TB_HZ / (CLK_HZ / 10)));
    pulse(stop, 1);
    $display("test internal done");
    for (int p = 0; p < 2; p++) begin
      d = 10 * $urandom_range(9, 1);
      cfg[0] = '{SRC_EXT, GATE_NONE, pol_e'(p), d[6:0], 32'h0000_000a};
      pulse(start, 0);
      src_en[0] = 1'b1;
      tick(300);
      act = 0;
      repeat (1000) begin
        @(negedge clk);
        act += (pulse_out[0] === 1'(p));
      end
      chk(act, 10 * d);
      src_en[0] = 1'b0;
      pulse(stop, 0);
    end
    $display("test duty done");
    summarize();
  end
endmodule
